/* design/pbb_bridge.sv */
// peripheral bus bridge master: upstream request port to two-phase peripheral transfers
`timescale 1ns/1ps
module pbb_bridge
  import pbb_pkg::*;
(
  input  wire logic               clk_i,        // clock, rising edge only
  input  wire logic               rst_i,        // async reset, active high
  input  wire logic               req_valid_i,  // upstream request valid
  input  wire logic               req_write_i,  // upstream request is a write
  input  wire logic [ADDR_W-1:0]  req_addr_i,   // upstream address
  input  wire logic [DATA_W-1:0]  req_wdata_i,  // upstream write data
  output logic                    req_ready_o,  // request taken when valid and ready
  output logic                    rsp_done_o,   // one-cycle completion pulse
  output logic                    rsp_err_o,    // completion was to an unmapped address
  output logic      [DATA_W-1:0]  rsp_rdata_o,  // read data of last read
  output logic      [ADDR_W-1:0]  paddr_o,      // peripheral address
  output logic                    pwrite_o,     // peripheral direction, high for write
  output logic      [DATA_W-1:0]  pwdata_o,     // peripheral write data
  output logic      [NUM_SLV-1:0] psel_o,       // peripheral selects
  output logic                    penable_o,    // peripheral enable strobe
  input  wire logic [DATA_W-1:0]  prdata_i      // peripheral read data
);

  pbb_ctl_s q, nxt;

  logic               pend;
  logic               pend_write;
  logic [ADDR_W-1:0]  pend_addr;
  logic [DATA_W-1:0]  pend_wdata;
  logic [NUM_SLV-1:0] pend_sel;
  logic               pend_hit;
  logic               pop;

  // the bridge is the only driver of the peripheral side; upstream it only answers
  pbb_req_hold u_hold (  // [RULE18]
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .valid_i (req_valid_i),
    .write_i (req_write_i),
    .addr_i  (req_addr_i),
    .wdata_i (req_wdata_i),
    .ready_o (req_ready_o),
    .pop_i   (pop),
    .pend_o  (pend),
    .write_o (pend_write),
    .addr_o  (pend_addr),
    .wdata_o (pend_wdata)
  );

  pbb_decode u_decode (
    .addr_i (pend_addr),
    .sel_o  (pend_sel),
    .hit_o  (pend_hit)
  );

  // a new transfer may begin from idle or straight after an enable cycle
  assign pop = pend && (q.state == PBB_IDLE || q.state == PBB_ENABLE);  // [RULE5]

  always_comb begin
    nxt      = q;
    nxt.done = 1'b0;
    case (q.state)
      PBB_IDLE: begin
        // address and direction are left alone to save toggling
        if (pend) begin
          nxt.state = PBB_SETUP;  // [RULE2]
        end else begin
          nxt.state = PBB_IDLE;   // [RULE1] [RULE11]
        end
      end
      PBB_SETUP: begin
        nxt.state   = PBB_ENABLE;  // [RULE3]
        nxt.penable = 1'b1;        // [RULE4] [RULE7]
      end
      PBB_ENABLE: begin
        nxt.penable = 1'b0;        // [RULE10]
        nxt.done    = 1'b1;        // [RULE20]
        nxt.err     = q.miss;
        if (!q.pwrite) begin
          // unmapped reads return zero, not a floating bus
          nxt.rdata = q.miss ? DATA_RST : prdata_i;  // [RULE13] [RULE17]
        end
        if (pend) begin
          nxt.state = PBB_SETUP;   // [RULE5]
        end else begin
          nxt.state = PBB_IDLE;    // [RULE5]
          nxt.psel  = SEL_NONE;    // [RULE10]
        end
      end
      default: begin
        nxt.state   = PBB_IDLE;
        nxt.psel    = SEL_NONE;
        nxt.penable = 1'b0;
      end
    endcase
    // load the latched request; same peripheral keeps its select high
    if (pop) begin
      nxt.paddr  = pend_addr;   // [RULE8] [RULE15]
      nxt.pwrite = pend_write;  // [RULE8]
      nxt.psel   = pend_sel;    // [RULE16] [RULE10]
      nxt.miss   = !pend_hit;
      if (pend_write) begin
        nxt.pwdata = pend_wdata;  // [RULE17]
      end
    end
  end

  // single rising-edge register for every output except req_ready_o, which comes from the holding register; no falling-edge logic
  always_ff @(posedge clk_i or posedge rst_i) begin  // [RULE14]
    if (rst_i) begin
      q <= CTL_RST;  // [RULE19]
    end else begin
      q <= nxt;
    end
  end

  assign paddr_o     = q.paddr;
  assign pwrite_o    = q.pwrite;
  assign pwdata_o    = q.pwdata;
  assign psel_o      = q.psel;
  assign penable_o   = q.penable;
  assign rsp_done_o  = q.done;
  assign rsp_err_o   = q.err;
  assign rsp_rdata_o = q.rdata;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_setup;
    q.state == PBB_SETUP && !penable_o;
  endsequence

  sequence s_enable;
    q.state == PBB_ENABLE && penable_o;
  endsequence

  sequence s_transfer;
    s_setup ##1 s_enable;
  endsequence

  sequence s_idle;
    q.state == PBB_IDLE && !penable_o;
  endsequence

  sequence s_back;
    s_enable ##1 s_setup;
  endsequence

  property p_idle_quiet;
    q.state == PBB_IDLE |-> !penable_o && psel_o == SEL_NONE;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)  // [RULE1]
    else $error("idle with select or enable active");

  property p_pend_starts;
    q.state == PBB_IDLE && pend |=> s_setup;
  endproperty
  a_pend_starts: assert property (p_pend_starts)  // [RULE2]
    else $error("pending request did not start setup");

  property p_setup_sel;
    q.state == PBB_SETUP && !q.miss |-> $onehot(psel_o);
  endproperty
  a_setup_sel: assert property (p_setup_sel)  // [RULE2]
    else $error("setup without one select");

  property p_setup_one;
    s_setup |=> s_enable;
  endproperty
  a_setup_one: assert property (p_setup_one)  // [RULE3]
    else $error("setup not followed by enable");

  property p_stable;
    s_setup |=> $stable(paddr_o) && $stable(pwrite_o) && $stable(psel_o)
                && $stable(pwdata_o);
  endproperty
  a_stable: assert property (p_stable)  // [RULE4]
    else $error("address, direction or select moved into enable");

  property p_enable_one;
    s_enable |=> !penable_o && (q.state == PBB_IDLE || q.state == PBB_SETUP);
  endproperty
  a_enable_one: assert property (p_enable_one)  // [RULE5]
    else $error("enable longer than one cycle");

  property p_pen_clean;
    $rose(penable_o) |-> $past(q.state) == PBB_SETUP;
  endproperty
  a_pen_clean: assert property (p_pen_clean)  // [RULE7]
    else $error("enable rose outside a setup to enable step");

  property p_idle_drop;
    s_enable ##1 q.state == PBB_IDLE |-> psel_o == SEL_NONE;
  endproperty
  a_idle_drop: assert property (p_idle_drop)  // [RULE10]
    else $error("select held after last transfer");

  property p_hold_idle;
    q.state != PBB_SETUP |-> $stable(paddr_o) && $stable(pwrite_o);
  endproperty
  a_hold_idle: assert property (p_hold_idle)  // [RULE11]
    else $error("address or direction moved outside setup");

  property p_rdata;
    s_enable and (!pwrite_o && !q.miss) |=> rsp_rdata_o == $past(prdata_i);
  endproperty
  a_rdata: assert property (p_rdata)  // [RULE13]
    else $error("read data not captured at end of enable");

  property p_onehot;
    $onehot0(psel_o);
  endproperty
  a_onehot: assert property (p_onehot)  // [RULE16]
    else $error("more than one select active");

  property p_done;
    s_transfer |=> rsp_done_o ##1 !rsp_done_o;
  endproperty
  a_done: assert property (p_done)  // [RULE20]
    else $error("completion not reported after enable");

  property p_done_cause;
    rsp_done_o |-> $past(q.state) == PBB_ENABLE;
  endproperty
  a_done_cause: assert property (p_done_cause)  // [RULE20]
    else $error("completion without a finished transfer");

  property p_wdata;
    $rose(q.state == PBB_SETUP) && pwrite_o |-> pwdata_o == $past(pend_wdata)
                                              && paddr_o == $past(pend_addr);
  endproperty
  a_wdata: assert property (p_wdata)  // [RULE17]
    else $error("setup does not carry the latched request");

  property p_rst_idle;
    $fell(rst_i) |-> q.state == PBB_IDLE && !penable_o && psel_o == SEL_NONE
                     && req_ready_o;
  endproperty
  a_rst_idle: assert property (p_rst_idle)  // [RULE19]
    else $error("bus not idle after reset");

  property p_en_strobe;
    q.state == PBB_ENABLE |-> penable_o;
  endproperty
  a_en_strobe: assert property (p_en_strobe)  // [RULE4]
    else $error("enable phase without the strobe");

  property p_pen_fall;
    $fell(penable_o) |-> $past(q.state) == PBB_ENABLE;
  endproperty
  a_pen_fall: assert property (p_pen_fall)  // [RULE7]
    else $error("strobe fell outside the end of an enable phase");

  property p_en_valid;
    s_transfer |-> $stable(paddr_o) && $stable(pwrite_o) && $stable(psel_o)
                   && $stable(pwdata_o);
  endproperty
  a_en_valid: assert property (p_en_valid)  // [RULE9]
    else $error("outputs moved during the enable phase");

  property p_back;
    s_enable and pend |=> s_setup;
  endproperty
  a_back: assert property (p_back)  // [RULE5]
    else $error("queued transfer did not follow enable directly");

  property p_same_sel;
    s_enable and (pend && pend_sel == psel_o && psel_o != SEL_NONE)
      |=> $stable(psel_o);
  endproperty
  a_same_sel: assert property (p_same_sel)  // [RULE10]
    else $error("select dropped between transfers to one peripheral");

  property p_new_sel;
    s_enable and pend |=> psel_o == $past(pend_sel);
  endproperty
  a_new_sel: assert property (p_new_sel)  // [RULE16]
    else $error("next transfer does not carry its decoded select");

  property p_idle_hold;
    s_idle ##1 s_idle |-> $stable(paddr_o) && $stable(pwrite_o)
                          && psel_o == SEL_NONE;
  endproperty
  a_idle_hold: assert property (p_idle_hold)  // [RULE11]
    else $error("address or direction toggled while idle");

  property p_addr_src;
    $rose(q.state == PBB_SETUP) |-> paddr_o == $past(pend_addr)
                                    && pwrite_o == $past(pend_write);
  endproperty
  a_addr_src: assert property (p_addr_src)  // [RULE15] [RULE8]
    else $error("setup address or direction not from the latched request");

  property p_miss_sel;
    q.miss |-> psel_o == SEL_NONE;
  endproperty
  a_miss_sel: assert property (p_miss_sel)  // [RULE16]
    else $error("select raised for an unmapped address");

  property p_err;
    s_enable |=> rsp_err_o == $past(q.miss);
  endproperty
  a_err: assert property (p_err)  // [RULE20]
    else $error("completion status does not match the decode");

  property p_rdata_keep;
    s_enable and pwrite_o |=> $stable(rsp_rdata_o);
  endproperty
  a_rdata_keep: assert property (p_rdata_keep)  // [RULE17]
    else $error("write changed the returned read data");

  property p_rdata_quiet;
    !rsp_done_o |-> $stable(rsp_rdata_o) && $stable(rsp_err_o);
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet)  // [RULE20]
    else $error("response moved without a completion");

  property p_miss_read;
    s_enable and (!pwrite_o && q.miss) |=> rsp_rdata_o == DATA_RST;
  endproperty
  a_miss_read: assert property (p_miss_read)  // [RULE17]
    else $error("unmapped read returned nonzero data");

  property p_take;
    req_valid_i && req_ready_o |=> pend;
  endproperty
  a_take: assert property (p_take)  // [RULE15]
    else $error("accepted request was not latched");

  property p_hold_pend;
    pend && q.state == PBB_SETUP |=> pend && !req_ready_o;
  endproperty
  a_hold_pend: assert property (p_hold_pend)  // [RULE20]
    else $error("queued request released during setup");

  property p_pwdata_keep;
    $rose(q.state == PBB_SETUP) && !pwrite_o |-> $stable(pwdata_o);
  endproperty
  a_pwdata_keep: assert property (p_pwdata_keep)  // [RULE17]
    else $error("write data toggled for a read");

  property p_back_addr;
    s_back |-> paddr_o == $past(pend_addr);
  endproperty
  a_back_addr: assert property (p_back_addr)  // [RULE8]
    else $error("back to back setup lacks the queued address");

  property p_idle_stay;
    s_idle and !pend |=> s_idle;
  endproperty
  a_idle_stay: assert property (p_idle_stay)  // [RULE1]
    else $error("bus left idle with nothing pending");

endmodule // pbb_bridge

/* design/pbb_pkg.sv */
// package for the peripheral bus bridge master: constants, types, decode function
// Overview of operation
// RULE1: bus rests in idle when nothing pending
// RULE2: setup asserts the addressed peripheral's select
// RULE3: setup lasts one cycle, then enable
// RULE4: enable strobe high; address, direction, select stable
// RULE5: enable one cycle, then idle or setup
// RULE6: peripherals tolerate glitches entering back-to-back setup
// RULE7: enable strobe comes clean from a flip-flop
// RULE8: outputs change after the edge starting setup
// RULE9: outputs stay valid throughout the enable cycle
// RULE10: drop strobe; drop select unless same peripheral
// RULE11: hold address and direction between transfers
// RULE12: peripheral presents read data during enable
// RULE13: capture read data at edge ending enable
// RULE14: everything on the rising clock edge only
// RULE15: latch upstream address, hold for whole transfer
// RULE16: decode address to at most one select
// RULE17: forward write data; return read data upstream
// RULE18: bridge sole peripheral master, upstream slave
// RULE19: reset gives idle, no select, no strobe
// RULE20: hold requester, report completion with read data
package pbb_pkg;

  localparam int ADDR_W  = 32;
  localparam int DATA_W  = 32;
  localparam int NUM_SLV = 4;
  // select index field of the address
  localparam int SEL_LSB = 12;
  localparam int SEL_W   = 4;

  localparam logic [ADDR_W-1:0]  ADDR_RST  = 32'h0000_0000;
  localparam logic [DATA_W-1:0]  DATA_RST  = 32'h0000_0000;
  localparam logic [NUM_SLV-1:0] SEL_NONE  = 4'h0;

  typedef enum logic [1:0] {
    PBB_IDLE   = 2'b00,
    PBB_SETUP  = 2'b01,
    PBB_ENABLE = 2'b11
  } pbb_state_e;

  typedef struct packed {
    pbb_state_e          state;
    logic [ADDR_W-1:0]   paddr;
    logic                pwrite;
    logic [DATA_W-1:0]   pwdata;
    logic [NUM_SLV-1:0]  psel;
    logic                penable;
    logic                miss;
    logic [DATA_W-1:0]   rdata;
    logic                done;
    logic                err;
  } pbb_ctl_s;

  localparam pbb_ctl_s CTL_RST = '{
    state:   PBB_IDLE,
    paddr:   ADDR_RST,
    pwrite:  1'b0,
    pwdata:  DATA_RST,
    psel:    SEL_NONE,
    penable: 1'b0,
    miss:    1'b0,
    rdata:   DATA_RST,
    done:    1'b0,
    err:     1'b0
  };

  typedef struct packed {
    logic               full;
    logic               write;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  wdata;
  } pbb_hold_s;

  localparam pbb_hold_s HOLD_RST = '{
    full:  1'b0,
    write: 1'b0,
    addr:  ADDR_RST,
    wdata: DATA_RST
  };

  // one-hot select from the index field; zero for an unmapped index
  function automatic logic [NUM_SLV-1:0] pbb_decode_f(input logic [ADDR_W-1:0] addr);
    logic [SEL_W-1:0]   idx;
    logic [NUM_SLV-1:0] sel;
    idx = addr[SEL_LSB +: SEL_W];
    sel = SEL_NONE;
    for (int i = 0; i < NUM_SLV; i++) begin
      if (idx == SEL_W'(i)) begin
        sel[i] = 1'b1;
      end
    end
    return sel;
  endfunction

endpackage

/* design/pbb_decode.sv */
// address decoder: latched address to one-hot peripheral select
`timescale 1ns/1ps
module pbb_decode
  import pbb_pkg::*;
(
  input  wire logic [ADDR_W-1:0]  addr_i,  // address to decode
  output logic      [NUM_SLV-1:0] sel_o,   // one-hot select
  output logic                    hit_o    // address maps to a peripheral
);

  always_comb begin
    sel_o = pbb_decode_f(addr_i);  // [RULE16]
    hit_o = |sel_o;
  end

endmodule // pbb_decode

/* design/pbb_req_hold.sv */
// one-entry holding register for an upstream request waiting for the peripheral bus
`timescale 1ns/1ps
module pbb_req_hold
  import pbb_pkg::*;
(
  input  wire logic              clk_i,    // clock
  input  wire logic              rst_i,    // async reset, active high
  input  wire logic              valid_i,  // upstream request
  input  wire logic              write_i,  // request is a write
  input  wire logic [ADDR_W-1:0] addr_i,   // request address
  input  wire logic [DATA_W-1:0] wdata_i,  // request write data
  output logic                   ready_o,  // entry free
  input  wire logic              pop_i,    // controller takes the entry
  output logic                   pend_o,   // entry holds a request
  output logic                   write_o,  // held direction
  output logic      [ADDR_W-1:0] addr_o,   // held address
  output logic      [DATA_W-1:0] wdata_o   // held write data
);

  pbb_hold_s q, nxt;

  // the entry lets the next address be taken while the current transfer runs
  always_comb begin
    nxt = q;
    if (pop_i) begin
      nxt.full = 1'b0;
    end
    if (valid_i && !q.full) begin
      nxt.full  = 1'b1;  // [RULE15]
      nxt.write = write_i;
      nxt.addr  = addr_i;
      nxt.wdata = wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= HOLD_RST;
    end else begin
      q <= nxt;
    end
  end

  assign ready_o = !q.full;
  assign pend_o  = q.full;
  assign write_o = q.write;
  assign addr_o  = q.addr;
  assign wdata_o = q.wdata;

endmodule // pbb_req_hold

/* testbench/pbb_slave_model.sv */
// peripheral slave model: zero-wait read data, scrambled when not driving
`timescale 1ns/1ps
module pbb_slave_model
  import pbb_pkg::*;
(
  input  wire logic               clk_i,      // clock
  input  wire logic               rst_i,      // async reset
  input  wire logic [ADDR_W-1:0]  paddr_i,    // address
  input  wire logic               pwrite_i,   // direction
  input  wire logic [NUM_SLV-1:0] psel_i,     // selects
  input  wire logic               penable_i,  // strobe
  output logic      [DATA_W-1:0]  prdata_o    // read data
);
  logic [DATA_W-1:0] last_r;
  logic              drive;
  // only the enable phase counts, so glitches between phases are harmless
  assign drive    = (psel_i != SEL_NONE) && penable_i && !pwrite_i;
  // data during enable, else inverse of last so stale data never matches
  assign prdata_o = drive ? (paddr_i ^ 32'ha5a5_a5a5) : ~last_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_r <= 32'h0;
    end else begin
      last_r <= prdata_o;
    end
  end
endmodule // pbb_slave_model

/* testbench/testbench.sv */
// self-checking bench for the peripheral bus bridge master
`timescale 1ns/1ps
module testbench;
  import pbb_pkg::*;
  logic              clk_i, rst_i, req_valid_i, req_write_i;
  logic [ADDR_W-1:0] req_addr_i, paddr_o;
  logic [DATA_W-1:0] req_wdata_i, rsp_rdata_o, pwdata_o, prdata_i;
  logic              req_ready_o, rsp_done_o, rsp_err_o, pwrite_o, penable_o;
  logic [NUM_SLV-1:0] psel_o;
  int                miscompares, comparisons;
  logic              pen_seen;
  logic [31:0]       pa_seen;
  pbb_bridge u_pbb_bridge (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_ready_o(req_ready_o), .rsp_done_o(rsp_done_o), .rsp_err_o(rsp_err_o),
    .rsp_rdata_o(rsp_rdata_o), .paddr_o(paddr_o), .pwrite_o(pwrite_o),
    .pwdata_o(pwdata_o), .psel_o(psel_o), .penable_o(penable_o), .prdata_i(prdata_i));
  pbb_slave_model u_pbb_slave_model (.clk_i(clk_i), .rst_i(rst_i), .paddr_i(paddr_o),
    .pwrite_i(pwrite_o), .psel_i(psel_o), .penable_i(penable_o), .prdata_o(prdata_i));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk1(string n, logic e, logic g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic chk32(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask
  // hold the request until a negedge sees ready, so the next rising edge takes it;
  // k keeps valid up so a follow-on request is queued with no gap
  task automatic send(logic w, logic [31:0] a, logic [31:0] d, logic k);
    int n;
    req_valid_i = 1'b1;
    req_write_i = w;
    req_addr_i  = a;
    req_wdata_i = d;
    for (n = 0; n < 20 && req_ready_o !== 1'b1; n++) @(negedge clk_i);
    if (n == 20) begin
      miscompares++;
      results();
    end
    @(negedge clk_i);
    if (!k) req_valid_i = 1'b0;
  endtask
  // wait for the enable phase, judge setup and enable, then completion
  // ha and hs: address and select expected once the enable phase is over
  task automatic watch(logic w, logic [31:0] a, logic [31:0] d, logic [3:0] s, logic er,
                       logic [31:0] ha, logic [3:0] hs);
    logic [31:0] pa;
    logic [3:0]  ps;
    logic        pe;
    int          n;
    pe = 1'b1;
    for (n = 0; n < 20 && penable_o !== 1'b1; n++) begin
      pa = paddr_o;
      ps = psel_o;
      pe = penable_o;
      @(negedge clk_i);
    end
    if (n == 20) begin
      miscompares++;
      results();
    end
    chk1("setup_penable", 1'b0, pe);
    chk32("setup_psel", {28'h0, s}, {28'h0, ps});
    chk32("setup_paddr", a, pa);
    chk32("en_paddr", a, paddr_o);
    chk32("en_psel", {28'h0, s}, {28'h0, psel_o});
    chk1("en_pwrite", w, pwrite_o);
    if (w) chk32("en_pwdata", d, pwdata_o);
    @(negedge clk_i);
    chk1("end_penable", 1'b0, penable_o);
    chk1("done", 1'b1, rsp_done_o);
    chk1("err", er, rsp_err_o);
    chk32("held_paddr", ha, paddr_o);
    chk32("end_psel", {28'h0, hs}, {28'h0, psel_o});
    chk1("held_pwrite", w, pwrite_o);
    if (!w) chk32("rdata", er ? 32'h0 : a ^ 32'ha5a5_a5a5, rsp_rdata_o);
    @(negedge clk_i);
    chk1("done_pulse", 1'b0, rsp_done_o);
    chk32("idle_psel", {28'h0, hs}, {28'h0, psel_o});
  endtask
  task automatic t_reset();
    chk32("rst_psel", 32'h0, {28'h0, psel_o});
    chk1("rst_penable", 1'b0, penable_o);
    chk1("rst_ready", 1'b1, req_ready_o);
  endtask
  task automatic t_write();
    send(1'b1, 32'h0000_1a3c, 32'hdead_0001, 1'b0);
    watch(1'b1, 32'h0000_1a3c, 32'hdead_0001, 4'h2, 1'b0, 32'h0000_1a3c, 4'h0);
  endtask
  task automatic t_read();
    send(1'b0, 32'h0000_3004, 32'h0, 1'b0);
    watch(1'b0, 32'h0000_3004, 32'h0, 4'h8, 1'b0, 32'h0000_3004, 4'h0);
  endtask
  task automatic t_unmapped();
    send(1'b0, 32'h0000_7010, 32'h0, 1'b0);
    watch(1'b0, 32'h0000_7010, 32'h0, 4'h0, 1'b1, 32'h0000_7010, 4'h0);
  endtask
  // two reads to one peripheral: select stays up from enable into the next setup
  task automatic t_b2b();
    fork
      begin
        send(1'b0, 32'h0000_0100, 32'h0, 1'b1);
        send(1'b0, 32'h0000_0200, 32'h0, 1'b0);
      end
      begin
        @(negedge clk_i);
        watch(1'b0, 32'h0000_0100, 32'h0, 4'h1, 1'b0, 32'h0000_0200, 4'h1);
      end
    join
    @(negedge clk_i);
    chk1("b2b_done", 1'b1, rsp_done_o);
    chk32("b2b_psel_end", 32'h0, {28'h0, psel_o});
  endtask
  initial begin
    rst_i       = 1'b1;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_addr_i  = 32'h0;
    req_wdata_i = 32'h0;
    miscompares = 0;
    comparisons = 0;
    repeat (10) @(negedge clk_i);
    t_reset();
    rst_i = 1'b0;
    @(negedge clk_i);
    t_write();
    t_read();
    t_unmapped();
    t_b2b();
    repeat (8) @(negedge clk_i);
    chk32("b2b_rdata", 32'h0000_0200 ^ 32'ha5a5_a5a5, rsp_rdata_o);
    results();
  end
  // in the back-to-back run the select may not drop between the two transfers
  always @(negedge clk_i) begin
    if (!rst_i && pen_seen === 1'b1 && pa_seen === 32'h0000_0100
        && paddr_o === 32'h0000_0200) begin
      chk32("b2b_psel", 32'h1, {28'h0, psel_o});
    end
    pen_seen <= penable_o;
    pa_seen  <= paddr_o;
  end
endmodule // testbench
